// file: ddc_pkg.sv
// Purpose: constants for the display data channel slave control block
// Assumes: register index times four gives the AXI4-Lite byte address
// Notes: bit positions follow the control and status layouts
package ddc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_MODE = 6'h05;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h0f;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
    localparam logic [5:0] IDX_SLV_ADDR = 6'h13;
    localparam logic [5:0] IDX_DATA = 6'h14;
    localparam logic [5:0] IDX_STATUS = 6'h15;

    // mode control fields
    localparam int MODE_SEL_BIT = 0;
    localparam logic [7:0] MODE_RST = 8'h07;
    // status control fields
    localparam int ST_START_BIT = 5;
    localparam int ST_STOP_BIT = 4;
    localparam int ST_DISABLE_BIT = 3;
    localparam int ST_TX_BIT = 2;
    localparam int ST_RECEIVED_ACK_FLAG_BIT = 1;
    localparam logic ST_DISABLE_RST = 1'b1;
    // interrupt fields, shared by status and mask
    localparam int IRQ_CLK_LOW_BIT = 5;
    localparam int IRQ_BYTE_BIT = 4;
    localparam int IRQ_ADDR_BIT = 3;
    localparam logic [7:0] IRQ_IMPL = 8'h38;

    localparam logic [7:0] SLV_ADDR_RST = 8'hff;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DEFAULT_SLV_ADDR = 8'ha0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [6:0] {
        LINK_IDLE = 7'h01,
        LINK_RECV = 7'h02,
        LINK_ACK = 7'h04,
        LINK_HOLD = 7'h08,
        LINK_SEND = 7'h10,
        LINK_GETACK = 7'h20,
        LINK_IGNORE = 7'h40
    } link_state_t;
endpackage

// file: ddc_slave_channel_control.sv
// Purpose: display data channel slave control, AXI4-Lite registers
// Assumes: clk_in 10 MHz; scl and sda sampled on clk_in
// Notes: open-drain pins; oe_n low means the pin is pulled low
// Function
// [RULE1] mode bit one selects DDC1, zero selects DDC2B
// [RULE2] mode bit comes out of reset in its DDC1 state
// [RULE3] hardware clears the mode bit when moving into DDC2B
// [RULE4] programmed slave address match raises address-match interrupt
// [RULE5] data register is the one byte buffer both ways
// [RULE6] clearing channel disable activates the channel; set keeps it idle
// [RULE7] when active, shared port pins become serial data and clock
// [RULE8] software sets transmit select to one for master reads
// [RULE9] each byte shifted out raises the byte-complete interrupt
// [RULE10] received-ack flag records the master's acknowledge of sent byte
// [RULE11] software steers DDC2B with clock-low, match and byte interrupts
// [RULE12] fixed default address also matches; mismatch ignores the transfer
// [RULE13] byte-complete on ninth clock falling edge, then clock held low
// [RULE14] data register write during the hold releases the clock
// [RULE15] start and stop flags set on detection, held until cleared
// [RULE16] disabled channel leaves pins as port pins, neither drives nor samples
module ddc_slave_channel_control
    import ddc_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic port_data_drive_low_in,
    input wire logic port_clock_drive_low_in,
    input wire logic shared_pin_data_in,
    output logic shared_pin_data_out,
    output logic shared_pin_data_oe_n_out,
    input wire logic shared_pin_clock_in,
    output logic shared_pin_clock_out,
    output logic shared_pin_clock_oe_n_out,
    output logic irq_out
);
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q, aw_have_q, w_have_q, wr_fire, wr_mapped, rd_mapped;
    logic [5:0] wr_idx, rd_idx;
    logic [7:0] rd_val;

    logic [7:0] mode_aux_q, slv_addr_q, data_q, shift_q, irq_stat_q;
    logic [7:0] irq_mask_q;
    logic mode_sel_q, channel_disable_q, tx_sel_q, received_ack_flag_q;
    logic start_flag_q, stop_flag_q;

    logic [2:0] scl_sync_q;
    logic [2:0] sda_sync_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic active;
    link_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic addr_phase_q;
    logic sda_low_q;
    logic scl_low_q;
    logic data_wr;
    logic addr_hit;
    logic byte_done_ev;
    logic addr_ev;
    logic clk_low_ev;

    // write side: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
    assign wr_idx = aw_addr_q[7:2];
    assign data_wr = wr_fire && w_lane0_q && wr_idx == IDX_DATA;
    always_comb begin
        case (wr_idx)
            IDX_MODE, IDX_IRQ_MASK, IDX_IRQ_STAT, IDX_SLV_ADDR, IDX_DATA,
            IDX_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_have_q && !s_axi_awready_out;
            s_axi_wready_out <= !w_have_q && !s_axi_wready_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata_in[7:0];
                w_lane0_q <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // read side
    assign rd_idx = s_axi_araddr_in[7:2];
    always_comb begin
        rd_val = 8'h00;
        rd_mapped = 1'b1;
        case (rd_idx)
            IDX_MODE: rd_val = {mode_aux_q[7:1], mode_sel_q};
            IDX_IRQ_MASK: rd_val = irq_mask_q;
            IDX_IRQ_STAT: rd_val = irq_stat_q;
            IDX_SLV_ADDR: rd_val = slv_addr_q;
            IDX_DATA: rd_val = data_q; // RULE5
            IDX_STATUS: begin
                rd_val[ST_START_BIT] = start_flag_q;
                rd_val[ST_STOP_BIT] = stop_flag_q;
                rd_val[ST_DISABLE_BIT] = channel_disable_q;
                rd_val[ST_TX_BIT] = tx_sel_q;
                rd_val[ST_RECEIVED_ACK_FLAG_BIT] = received_ack_flag_q; // RULE10
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= {24'h000000, rd_val};
                s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            scl_sync_q <= 3'b111;
            sda_sync_q <= 3'b111;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], shared_pin_clock_in};
            sda_sync_q <= {sda_sync_q[1:0], shared_pin_data_in};
        end
    end

    assign active = !channel_disable_q; // RULE6
    assign scl_rise = active && scl_sync_q[1] && !scl_sync_q[2]; // RULE16
    assign scl_fall = active && !scl_sync_q[1] && scl_sync_q[2];
    assign start_det = active && scl_sync_q[1] && scl_sync_q[2]
        && !sda_sync_q[1] && sda_sync_q[2];
    assign stop_det = active && scl_sync_q[1] && scl_sync_q[2]
        && sda_sync_q[1] && !sda_sync_q[2];
    assign addr_hit = shift_q[7:1] == slv_addr_q[7:1] // RULE4
        || shift_q[7:1] == DEFAULT_SLV_ADDR[7:1]; // RULE12

    // link engine
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= LINK_IDLE;
            bit_cnt_q <= '0;
            addr_phase_q <= 1'b0;
            shift_q <= '0;
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b0;
            received_ack_flag_q <= 1'b0;
            byte_done_ev <= 1'b0;
            addr_ev <= 1'b0;
        end else begin
            byte_done_ev <= 1'b0;
            addr_ev <= 1'b0;
            if (!active) begin
                state_q <= LINK_IDLE;
                sda_low_q <= 1'b0;
                scl_low_q <= 1'b0;
            end else if (start_det) begin
                state_q <= LINK_RECV;
                bit_cnt_q <= '0;
                addr_phase_q <= 1'b1;
                sda_low_q <= 1'b0;
                scl_low_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= LINK_IDLE;
                sda_low_q <= 1'b0;
            end else begin
                case (state_q)
                    LINK_RECV: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_sync_q[1]};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
                        begin
                            if (!addr_phase_q || addr_hit) begin
                                sda_low_q <= 1'b1;
                                addr_ev <= addr_phase_q; // RULE4
                                state_q <= LINK_ACK;
                            end else begin
                                state_q <= LINK_IGNORE; // RULE12
                            end
                        end
                    end
                    LINK_ACK: begin
                        if (scl_fall) begin
                            sda_low_q <= 1'b0;
                            scl_low_q <= 1'b1; // RULE13
                            byte_done_ev <= 1'b1; // RULE13
                            addr_phase_q <= 1'b0;
                            state_q <= LINK_HOLD;
                        end
                    end
                    LINK_HOLD: begin
                        if (data_wr) begin
                            scl_low_q <= tx_sel_q; // RULE14
                            bit_cnt_q <= '0;
                            if (tx_sel_q) begin // RULE8
                                shift_q <= w_data_q;
                                sda_low_q <= !w_data_q[7];
                                state_q <= LINK_SEND;
                            end else begin
                                state_q <= LINK_RECV;
                            end
                        end
                    end
                    LINK_SEND: begin
                        // the first bit gets a cycle of setup on sda
                        scl_low_q <= 1'b0; // RULE14
                        if (scl_fall) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            shift_q <= {shift_q[6:0], 1'b1};
                            if (bit_cnt_q == BITS_PER_BYTE - 4'h1) begin
                                sda_low_q <= 1'b0;
                                state_q <= LINK_GETACK;
                            end else begin
                                sda_low_q <= !shift_q[6];
                            end
                        end
                    end
                    LINK_GETACK: begin
                        if (scl_rise) begin
                            received_ack_flag_q <= sda_sync_q[1]; // RULE10
                        end else if (scl_fall) begin
                            scl_low_q <= 1'b1; // RULE13
                            byte_done_ev <= 1'b1; // RULE9
                            state_q <= LINK_HOLD;
                        end
                    end
                    LINK_IDLE, LINK_IGNORE: begin
                        sda_low_q <= 1'b0;
                    end
                    default: state_q <= LINK_IDLE;
                endcase
            end
        end
    end

    assign clk_low_ev = scl_fall && !mode_sel_q;

    // software registers; hardware sets win over clears
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode_sel_q <= MODE_RST[MODE_SEL_BIT]; // RULE2
            mode_aux_q <= MODE_RST;
            slv_addr_q <= SLV_ADDR_RST;
            data_q <= DATA_RST;
            channel_disable_q <= ST_DISABLE_RST;
            tx_sel_q <= 1'b0;
            start_flag_q <= 1'b0;
            stop_flag_q <= 1'b0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            if (wr_fire && w_lane0_q) begin
                case (wr_idx)
                    IDX_MODE: begin
                        mode_sel_q <= w_data_q[MODE_SEL_BIT]; // RULE1
                        mode_aux_q <= w_data_q;
                    end
                    IDX_IRQ_MASK: irq_mask_q <= w_data_q & IRQ_IMPL;
                    IDX_IRQ_STAT: irq_stat_q <= irq_stat_q & ~w_data_q;
                    IDX_SLV_ADDR: slv_addr_q <= w_data_q;
                    IDX_DATA: data_q <= w_data_q; // RULE5
                    IDX_STATUS: begin
                        channel_disable_q <= w_data_q[ST_DISABLE_BIT];
                        tx_sel_q <= w_data_q[ST_TX_BIT]; // RULE8
                        if (w_data_q[ST_START_BIT])
                            start_flag_q <= 1'b0;
                        if (w_data_q[ST_STOP_BIT])
                            stop_flag_q <= 1'b0;
                    end
                    default: ;
                endcase
            end
            if (start_det) begin
                start_flag_q <= 1'b1; // RULE15
                mode_sel_q <= 1'b0; // RULE3
            end
            if (stop_det)
                stop_flag_q <= 1'b1; // RULE15
            if (state_q == LINK_RECV && scl_fall
                    && bit_cnt_q == BITS_PER_BYTE)
                data_q <= shift_q; // RULE5
            // RULE11
            if (addr_ev)
                irq_stat_q[IRQ_ADDR_BIT] <= 1'b1;
            if (byte_done_ev)
                irq_stat_q[IRQ_BYTE_BIT] <= 1'b1;
            if (clk_low_ev)
                irq_stat_q[IRQ_CLK_LOW_BIT] <= 1'b1;
        end
    end

    // pin drivers: port function while disabled
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            shared_pin_data_out <= 1'b0;
            shared_pin_clock_out <= 1'b0;
            shared_pin_data_oe_n_out <= 1'b1;
            shared_pin_clock_oe_n_out <= 1'b1;
            irq_out <= 1'b0;
        end else begin
            shared_pin_data_out <= 1'b0;
            shared_pin_clock_out <= 1'b0;
            if (active) begin
                shared_pin_data_oe_n_out <= !sda_low_q; // RULE7
                shared_pin_clock_oe_n_out <= !scl_low_q; // RULE7
            end else begin
                shared_pin_data_oe_n_out <= !port_data_drive_low_in; // RULE16
                shared_pin_clock_oe_n_out <= !port_clock_drive_low_in;
            end
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule

// file: ddc_slave_properties.sv
// Purpose: port-level checks for the DDC slave control block
// Assumes: the bench resolves the open-drain lines onto the pin inputs
// Notes: bound to every instance of the top module
module ddc_slave_properties
    import ddc_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic port_data_drive_low_in,
    input wire logic port_clock_drive_low_in,
    input wire logic shared_pin_clock_in,
    input wire logic shared_pin_data_out,
    input wire logic shared_pin_data_oe_n_out,
    input wire logic shared_pin_clock_out,
    input wire logic shared_pin_clock_oe_n_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_write_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
            s_axi_wready_out && s_axi_wstrb_in[0];
    endsequence
    sequence s_data_write;
        s_write_taken ##0 s_axi_awaddr_in == {IDX_DATA, 2'b00} &&
            !port_clock_drive_low_in;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=>
        !s_axi_bvalid_out && !s_axi_rvalid_out && !irq_out &&
        shared_pin_clock_oe_n_out && shared_pin_data_oe_n_out)
        else $error("outputs not quiet after reset");
    a_pin_open_drain: assert property (!shared_pin_data_out &&
        !shared_pin_clock_out)
        else $error("shared pin driven high");
    a_hold_on_low: assert property (!port_clock_drive_low_in &&
        $fell(shared_pin_clock_oe_n_out) |-> !$past(shared_pin_clock_in))
        else $error("clock grabbed while line high");
    a_release_on_write: assert property (s_data_write |->
        ##[1:4] shared_pin_clock_oe_n_out)
        else $error("clock hold not released by data write");
    a_sda_when_low: assert property (!port_data_drive_low_in &&
        $changed(shared_pin_data_oe_n_out) |-> !shared_pin_clock_in)
        else $error("data line changed while clock high");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
        |=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0)
        else $error("read answer missing or wide");
    a_answer_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read answer dropped early");
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid_out)
        else $error("write response late");
    a_busy_refuses: assert property (s_axi_bvalid_out |->
        !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken while response pending");
endmodule
bind ddc_slave_channel_control ddc_slave_properties i_props (.clk_in,
    .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .port_data_drive_low_in,
    .port_clock_drive_low_in, .shared_pin_clock_in, .shared_pin_data_out,
    .shared_pin_data_oe_n_out, .shared_pin_clock_out,
    .shared_pin_clock_oe_n_out, .irq_out);

// file: ddc_host_model.sv
// Purpose: bus master model of the graphics host on the two-wire link
// Assumes: lines are open drain with pull-ups resolved by the bench
// Notes: honours clock stretching by waiting for the clock line to rise
module ddc_host_model (
    input wire logic clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    task automatic half();
        repeat (2) @(posedge clk_in);
    endtask
    task automatic let_go();
        @(posedge clk_in);
        scl_low_out <= 1'b0;
    endtask
    // release the clock and wait while the slave stretches it
    task automatic raise();
        let_go();
        @(posedge clk_in);
        while (!scl_in) @(posedge clk_in);
    endtask
    task automatic start();
        @(posedge clk_in);
        scl_low_out <= 1'b1;
        half();
        sda_low_out <= 1'b0;
        half();
        raise();
        half();
        sda_low_out <= 1'b1;
        half();
    endtask
    task automatic stop();
        @(posedge clk_in);
        scl_low_out <= 1'b1;
        sda_low_out <= 1'b1;
        half();
        raise();
        half();
        sda_low_out <= 1'b0;
        half();
    endtask
    // nine clocks: eight data bits and the acknowledge slot
    task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            @(posedge clk_in);
            scl_low_out <= 1'b1;
            half();
            sda_low_out <= !tx[i];
            half();
            raise();
            @(posedge clk_in);
            rx[i] = sda_in;
        end
        @(posedge clk_in);
        scl_low_out <= 1'b1;
        half();
        sda_low_out <= 1'b0;
        half();
    endtask
endmodule

// file: testbench.sv
// Purpose: register and link level test of the DDC slave control block
// Assumes: AXI4-Lite master tasks and a host model on the link
// Notes: wstrb is fixed to the low byte lane
module testbench;
    import ddc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic pd_low = 1'b0, pc_low = 1'b0;
    logic awr, wr, bv, arr, rv, irq, sda_o, sda_oe_n, scl_o, scl_oe_n;
    logic m_scl, m_sda;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [8:0] rx;
    wire logic scl = !(m_scl || !scl_oe_n);
    wire logic sda = !(m_sda || !sda_oe_n);
    int n_mismatch = 0, comparisons = 0;
    logic [5:0] idx [5] = '{IDX_MODE, IDX_IRQ_MASK, IDX_IRQ_STAT, IDX_DATA,
        IDX_STATUS};
    logic [7:0] rstv [5] = '{MODE_RST, 8'h00, 8'h00, DATA_RST, 8'h08};
    logic [7:0] txv [2] = '{8'hc3, 8'h69};
    logic ackv [2] = '{1'b0, 1'b1};
    always #50 clk = ~clk;
    ddc_slave_channel_control i_ddc_slave_channel_control (.clk_in(clk),
        .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rready),
        .port_data_drive_low_in(pd_low), .port_clock_drive_low_in(pc_low),
        .shared_pin_data_in(sda), .shared_pin_data_out(sda_o),
        .shared_pin_data_oe_n_out(sda_oe_n), .shared_pin_clock_in(scl),
        .shared_pin_clock_out(scl_o), .shared_pin_clock_oe_n_out(scl_oe_n),
        .irq_out(irq));
    ddc_host_model i_ddc_host_model (.clk_in(clk), .scl_in(scl),
        .sda_in(sda), .scl_low_out(m_scl), .sda_low_out(m_sda));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wr_reg(input logic [5:0] i, input logic [7:0] v,
        input logic [1:0] er);
        @(posedge clk);
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (awv || wv);
        while (!bv) @(posedge clk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd_chk(input logic [5:0] i, input logic [7:0] v,
        input logic [1:0] er);
        @(posedge clk);
        araddr <= {i, 2'b00};
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        rready <= 1'b0;
        chk(rdata, {24'h0, v});
        chk(rresp, er);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++) rd_chk(idx[k], rstv[k], RESP_OKAY);
        rd_chk(6'h00, 8'h00, RESP_SLVERR);
        wr_reg(6'h00, 8'hff, RESP_SLVERR);
        $display("test reset values done");
        pc_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk(scl_oe_n, 1'b0);
        pc_low <= 1'b0;
        i_ddc_host_model.start();
        i_ddc_host_model.stop();
        rd_chk(IDX_STATUS, 8'h08, RESP_OKAY);
        $display("test disabled channel done");
        wr_reg(IDX_IRQ_MASK, IRQ_IMPL, RESP_OKAY);
        wr_reg(IDX_SLV_ADDR, 8'h6c, RESP_OKAY);
        wr_reg(IDX_STATUS, 8'h00, RESP_OKAY);
        pc_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk(scl_oe_n, 1'b1);
        pc_low <= 1'b0;
        i_ddc_host_model.start();
        i_ddc_host_model.xbyte({8'h6c, 1'b1}, rx);
        chk(rx[0], 1'b0);
        rd_chk(IDX_IRQ_STAT, IRQ_IMPL, RESP_OKAY);
        rd_chk(IDX_MODE, 8'h06, RESP_OKAY);
        rd_chk(IDX_STATUS, 8'h20, RESP_OKAY);
        rd_chk(IDX_DATA, 8'h6c, RESP_OKAY);
        chk(irq, 1'b1);
        wr_reg(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr_reg(IDX_IRQ_MASK, IRQ_IMPL, RESP_OKAY);
        wr_reg(IDX_IRQ_STAT, IRQ_IMPL, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        repeat (8) @(posedge clk);
        chk(scl_oe_n, 1'b0);
        wr_reg(IDX_DATA, 8'h00, RESP_OKAY);
        repeat (4) @(posedge clk);
        chk(scl_oe_n, 1'b1);
        i_ddc_host_model.xbyte({8'h5a, 1'b1}, rx);
        chk(rx[0], 1'b0);
        rd_chk(IDX_DATA, 8'h5a, RESP_OKAY);
        $display("test write transfer done");
        i_ddc_host_model.let_go();
        wr_reg(IDX_DATA, 8'h00, RESP_OKAY);
        i_ddc_host_model.start();
        i_ddc_host_model.xbyte({8'ha1, 1'b1}, rx);
        chk(rx[0], 1'b0);
        wr_reg(IDX_STATUS, 8'h04, RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            wr_reg(IDX_DATA, txv[k], RESP_OKAY);
            i_ddc_host_model.xbyte({8'hff, ackv[k]}, rx);
            chk(rx[8:1], txv[k]);
            rd_chk(IDX_STATUS, {6'h09, ackv[k], 1'b0}, RESP_OKAY);
        end
        wr_reg(IDX_DATA, 8'hff, RESP_OKAY);
        i_ddc_host_model.stop();
        rd_chk(IDX_STATUS, 8'h36, RESP_OKAY);
        $display("test read transfer done");
        wr_reg(IDX_STATUS, 8'h30, RESP_OKAY);
        wr_reg(IDX_IRQ_STAT, IRQ_IMPL, RESP_OKAY);
        i_ddc_host_model.start();
        i_ddc_host_model.xbyte({8'h30, 1'b1}, rx);
        chk(rx[0], 1'b1);
        rd_chk(IDX_IRQ_STAT, 8'h20, RESP_OKAY);
        i_ddc_host_model.let_go();
        repeat (8) @(posedge clk);
        chk(scl, 1'b1);
        i_ddc_host_model.stop();
        $display("test address mismatch done");
        wr_reg(IDX_MODE, 8'h07, RESP_OKAY);
        rd_chk(IDX_MODE, 8'h07, RESP_OKAY);
        $display("test mode select done");
        results();
    end
endmodule
